// >>> include/mel_defs.vh
// Register offsets, field positions and reset values of the latched event bank.
// Assumes inclusion by the single design module; definitions only.
`ifndef MEL_DEFS_VH
`define MEL_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define MEL_OFF_EVENT      12'h000
`define MEL_OFF_FAULT_EN   12'h004
`define MEL_OFF_IRQ_STAT   12'h008
`define MEL_OFF_IRQ_EN     12'h00c
`define MEL_OFF_IRQ_CLR    12'h010

// ----------------------------------------------------------------------------
// Event field positions
// ----------------------------------------------------------------------------
`define MEL_BIT_FREQ_LO    9
`define MEL_BIT_FREQ_HI    13
`define MEL_BIT_XB_ST      8
`define MEL_BIT_XA_ST      7
`define MEL_BIT_PPM_ERR    6
`define MEL_BIT_PPM_WARN   5
`define MEL_BIT_LOS_B      4
`define MEL_BIT_LOS_A      3
`define MEL_BIT_PLL_LOL    2
`define MEL_BIT_RSVD       1
`define MEL_BIT_POST       0

// ----------------------------------------------------------------------------
// Fault enable field positions
// ----------------------------------------------------------------------------
`define MEL_FEN_PPM_WARN   5
`define MEL_FEN_LOS_B      4
`define MEL_FEN_LOS_A      3
`define MEL_FEN_PLL_LOL    2
`define MEL_FEN_POST       0

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define MEL_EVENT_RST      14'h0000
`define MEL_FEN_RST        6'h00
`define MEL_FEN_MASK       6'h3d
`define MEL_IRQ_RST        14'h0000
`define MEL_EVENT_MASK     14'h3ffd

`endif

// >>> rtl/mel_event_latch.v
// Latched device event bits 13..0 with fault and interrupt outputs, APB slave.
// Assumes monitor inputs arrive from logic on pclk; the POST and lock inputs
// are levels from other domains and are synchronised here.
//
// Overview of operation
// - Output clock failures latch bits 13 to 9.
// - Crystal B short-term error sets bit 8.
// - Crystal A short-term error sets bit 7.
// - Ppm error sets bit 6.
// - Ppm warning sets bit 5.
// - Crystal B signal loss sets bit 4.
// - Crystal A signal loss sets bit 3.
// - Loss bits show loss since last clear.
// - Bit 2 sets only on lock-to-unlock edge.
// - Self test failure sets bit 0.
// - Bits reset zero, cleared by writing one.
// - Enabled loss bits drive fault output.
// - Enabled warn, lol, post bits drive fault.
`timescale 1ns/1ns
`include "mel_defs.vh"

module mel_event_latch #(
  parameter NUM_OUT = 5
) (
  input  wire               pclk,
  input  wire               presetn,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  input  wire [3:0]         pstrb,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  input  wire [NUM_OUT-1:0] out_freq_fail_true,
  input  wire [NUM_OUT-1:0] out_freq_fail_comp,
  input  wire               crystal_b_short_term_error,
  input  wire               crystal_a_short_term_error,
  input  wire               ppm_error,
  input  wire               ppm_warning,
  input  wire               crystal_b_signal_loss,
  input  wire               crystal_a_signal_loss,
  input  wire               pll_locked,
  input  wire               post_failure,
  output reg                device_fault,
  output reg                irq
);

  // --------------------------------------------------------------------------
  // Asynchronous inputs: three flops, change accepted when stages 2 and 3 agree
  // --------------------------------------------------------------------------
  reg  [1:0] sync1_ff;
  reg  [1:0] sync2_ff;
  reg  [1:0] sync3_ff;
  reg  [1:0] filt_ff;
  reg  [1:0] nxt_filt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      sync3_ff <= 2'h0;
    end else begin
      sync1_ff <= {pll_locked, post_failure};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always @* begin
    nxt_filt = filt_ff;
    if (sync2_ff[0] == sync3_ff[0])
      nxt_filt[0] = sync3_ff[0];
    if (sync2_ff[1] == sync3_ff[1])
      nxt_filt[1] = sync3_ff[1];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      filt_ff <= 2'h0;
    else
      filt_ff <= nxt_filt;
  end

  wire post_fail_lvl = filt_ff[0];
  wire lock_lvl      = filt_ff[1];

  // Lock is taken as absent after reset so no event fires before first lock.
  reg  lock_prev_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lock_prev_ff <= 1'b0;
    else
      lock_prev_ff <= lock_lvl;
  end
  wire lol_edge = lock_prev_ff & ~lock_lvl;

  // --------------------------------------------------------------------------
  // Event set vector
  // --------------------------------------------------------------------------
  wire [NUM_OUT-1:0] freq_fail = out_freq_fail_true | out_freq_fail_comp;
  reg  [13:0]        evt_set;

  always @* begin
    evt_set = 14'h0000;
    evt_set[`MEL_BIT_FREQ_HI:`MEL_BIT_FREQ_LO] = freq_fail[4:0];
    evt_set[`MEL_BIT_XB_ST]    = crystal_b_short_term_error;
    evt_set[`MEL_BIT_XA_ST]    = crystal_a_short_term_error;
    evt_set[`MEL_BIT_PPM_ERR]  = ppm_error;
    evt_set[`MEL_BIT_PPM_WARN] = ppm_warning;
    evt_set[`MEL_BIT_LOS_B]    = crystal_b_signal_loss;
    evt_set[`MEL_BIT_LOS_A]    = crystal_a_signal_loss;
    evt_set[`MEL_BIT_PLL_LOL]  = lol_edge;
    evt_set[`MEL_BIT_POST]     = post_fail_lvl;
  end

  // --------------------------------------------------------------------------
  // APB decode; zero wait states, every access completes in its access phase
  // --------------------------------------------------------------------------
  wire        acc      = psel & penable;
  wire        wr       = acc & pwrite;
  wire [31:0] wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] wdat     = pwdata & wmask;
  wire        hit_evt  = (paddr == `MEL_OFF_EVENT);
  wire        hit_fen  = (paddr == `MEL_OFF_FAULT_EN);
  wire        hit_ist  = (paddr == `MEL_OFF_IRQ_STAT);
  wire        hit_ien  = (paddr == `MEL_OFF_IRQ_EN);
  wire        hit_icl  = (paddr == `MEL_OFF_IRQ_CLR);
  wire        mapped   = hit_evt | hit_fen | hit_ist | hit_ien | hit_icl;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [13:0] event_ff;
  reg  [13:0] nxt_event;
  reg  [5:0]  fault_en_ff;
  reg  [13:0] irq_stat_ff;
  reg  [13:0] nxt_irq_stat;
  reg  [13:0] irq_en_ff;
  reg  [13:0] evt_clr;
  reg  [13:0] irq_clr;

  always @* begin
    evt_clr = 14'h0000;
    if (wr && hit_evt)
      evt_clr = wdat[13:0];
    // Set takes priority over a clear in the same cycle.
    nxt_event = ((event_ff & ~evt_clr) | evt_set) & `MEL_EVENT_MASK;
  end

  always @* begin
    irq_clr = 14'h0000;
    if (wr && hit_icl)
      irq_clr = wdat[13:0];
    nxt_irq_stat = ((irq_stat_ff & ~irq_clr) | evt_set) & `MEL_EVENT_MASK;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_ff    <= `MEL_EVENT_RST;
      fault_en_ff <= `MEL_FEN_RST;
      irq_stat_ff <= `MEL_IRQ_RST;
      irq_en_ff   <= `MEL_IRQ_RST;
    end else begin
      event_ff    <= nxt_event;
      irq_stat_ff <= nxt_irq_stat;
      if (wr && hit_fen)
        fault_en_ff <= wdat[5:0] & `MEL_FEN_MASK;
      if (wr && hit_ien)
        irq_en_ff <= wdat[13:0] & `MEL_EVENT_MASK;
    end
  end

  // --------------------------------------------------------------------------
  // Fault and interrupt outputs
  // --------------------------------------------------------------------------
  wire nxt_fault =
      (fault_en_ff[`MEL_FEN_LOS_B]    & event_ff[`MEL_BIT_LOS_B])
    | (fault_en_ff[`MEL_FEN_LOS_A]    & event_ff[`MEL_BIT_LOS_A])
    | (fault_en_ff[`MEL_FEN_PPM_WARN] & event_ff[`MEL_BIT_PPM_WARN])
    | (fault_en_ff[`MEL_FEN_PLL_LOL]  & event_ff[`MEL_BIT_PLL_LOL])
    | (fault_en_ff[`MEL_FEN_POST]     & event_ff[`MEL_BIT_POST]);
  wire nxt_irq = |(irq_stat_ff & irq_en_ff);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_fault <= 1'b0;
      irq          <= 1'b0;
    end else begin
      device_fault <= nxt_fault;
      irq          <= nxt_irq;
    end
  end

  // --------------------------------------------------------------------------
  // Read data and bus answer, registered in the setup phase
  // --------------------------------------------------------------------------
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (hit_evt)
      nxt_rdata = {18'h00000, event_ff};
    else if (hit_fen)
      nxt_rdata = {26'h0000000, fault_en_ff};
    else if (hit_ist)
      nxt_rdata = {18'h00000, irq_stat_ff};
    else if (hit_ien)
      nxt_rdata = {18'h00000, irq_en_ff};
  end

  wire setup = psel & ~penable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite)
        prdata <= nxt_rdata;
      else if (!psel)
        prdata <= 32'h0000_0000;
    end
  end

endmodule // mel_event_latch

// >>> sim/mel_event_latch_assertions.sv
// Checker for the latched event bank: bus answers and read values.
// Assumes binding to mel_event_latch; sees only its ports.
`timescale 1ns/1ns
module mel_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [4:0]  out_freq_fail_true,
  input wire logic [4:0]  out_freq_fail_comp,
  input wire logic        crystal_b_short_term_error,
  input wire logic        crystal_a_short_term_error,
  input wire logic        ppm_error,
  input wire logic        ppm_warning,
  input wire logic        crystal_b_signal_loss,
  input wire logic        crystal_a_signal_loss
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ev;
  logic [5:0] mon;
  assign rd_ev = pready && !pwrite && paddr == 12'h000;
  assign mon = {crystal_b_short_term_error, crystal_a_short_term_error, ppm_error,
                ppm_warning, crystal_b_signal_loss, crystal_a_signal_loss};
  sequence s_setup; psel && !penable; endsequence
  property p_ans; s_setup |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_cause; pready |-> penable && $past(psel && !penable); endproperty
  a_cause: assert property (p_cause) else $error("ready without setup");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error answer carries data");
  property p_rsvd; rd_ev |-> prdata[31:14] == 18'h0 && !prdata[1]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_freq;
    rd_ev |-> (prdata[13:9] & $past(out_freq_fail_true | out_freq_fail_comp, 2))
              == $past(out_freq_fail_true | out_freq_fail_comp, 2);
  endproperty
  a_freq: assert property (p_freq) else $error("output failure not latched");
  property p_mon; rd_ev |-> (prdata[8:3] & $past(mon, 2)) == $past(mon, 2); endproperty
  a_mon: assert property (p_mon) else $error("monitor event lost");
  property p_wo; pready && !pwrite && paddr == 12'h010 |-> prdata == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("clear register reads nonzero");
endmodule // mel_chk
bind mel_event_latch mel_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .out_freq_fail_true, .out_freq_fail_comp,
  .crystal_b_short_term_error, .crystal_a_short_term_error, .ppm_error, .ppm_warning,
  .crystal_b_signal_loss, .crystal_a_signal_loss);

// >>> sim/mel_event_latch_bench.sv
// Self-checking bench for the latched event bank over APB.
// Assumes mel_event_latch and its checker are compiled before it.
`timescale 1ns/1ns
module mel_event_latch_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, device_fault, irq, pll_locked = 0, post_failure = 0;
  logic [15:0] src = '0, m;
  logic [32:0] exp_q[$];
  integer      err_total = 0, samples_checked = 0, seed = 60, cyc = 0, k;
  mel_event_latch u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .out_freq_fail_true(src[4:0]),
    .out_freq_fail_comp(src[9:5]), .crystal_a_signal_loss(src[10]),
    .crystal_b_signal_loss(src[11]), .ppm_warning(src[12]), .ppm_error(src[13]),
    .crystal_a_short_term_error(src[14]), .crystal_b_short_term_error(src[15]),
    .pll_locked, .post_failure, .device_fault, .irq);
  always #5 pclk = ~pclk;
  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task chk(input logic [32:0] got, input logic [32:0] want);
    samples_checked++;
    if (got !== want) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (pready && !pwrite && exp_q.size() > 0) chk({pslverr, prdata}, exp_q.pop_front());
    if (cyc > 5000) begin
      err_total++;
      conclude;
    end
  end
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge keeps a following call from re-driving psel in this time step.
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    bus(1'h0, a, 32'h0);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task fire(input logic [15:0] v);
    src <= v;
    @(posedge pclk);
    src <= '0;
  endtask
  task idle(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  // Event bit that each stimulus line sets.
  function automatic logic [13:0] map(input logic [15:0] v);
    map = '0;
    for (int j = 0; j < 16; j++) if (v[j]) map[j < 10 ? 9 + j % 5 : j - 7] = 1'h1;
  endfunction
  initial begin
    idle(8);
    presetn <= 1'h1;
    @(posedge pclk);
    for (k = 0; k < 6; k++) rd(k * 4, {k == 5, 32'h0});
    wr(12'h010, 32'hffffffff);
    rd(12'h010, 33'h0);
    $display("reset test done");
    for (k = 0; k < 16; k++) begin
      fire(16'h1 << k);
      wr(12'h000, 32'h0);
      rd(12'h000, map(16'h1 << k));
      wr(12'h000, 32'hffffffff);
      rd(12'h000, 33'h0);
    end
    $display("source test done");
    wr(12'h010, 32'hffffffff);
    for (k = 0; k < 6; k++) begin
      m = $random(seed);
      fire(m);
      rd(12'h008, map(m));
      chk(irq, 1'h0);
      wr(12'h00c, map(m));
      idle(2);
      chk(irq, |map(m));
      wr(12'h010, 32'hffffffff);
      rd(12'h000, map(m));
      wr(12'h000, 32'hffffffff);
      wr(12'h00c, 32'h0);
      chk(irq, 1'h0);
    end
    $display("random test done");
    src <= 16'h0800;
    wr(12'h000, 32'hffffffff);
    rd(12'h000, 33'h10);
    src <= '0;
    wr(12'h000, 32'hffffffff);
    rd(12'h000, 33'h0);
    pll_locked <= 1'h1;
    idle(8);
    rd(12'h000, 33'h0);
    pll_locked <= 1'h0;
    idle(8);
    rd(12'h000, 33'h4);
    wr(12'h000, 32'h4);
    idle(8);
    rd(12'h000, 33'h0);
    post_failure <= 1'h1;
    idle(8);
    post_failure <= 1'h0;
    pll_locked <= 1'h1;
    idle(8);
    pll_locked <= 1'h0;
    fire(16'h1c00);
    idle(8);
    rd(12'h000, 33'h3d);
    $display("lock test done");
    chk(device_fault, 1'h0);
    for (k = 0; k < 6; k++) if (k != 1) begin
      wr(12'h004, 32'h1 << k);
      idle(3);
      chk(device_fault, 1'h1);
      wr(12'h000, 32'h1 << k);
      idle(3);
      chk(device_fault, 1'h0);
    end
    wr(12'h004, 32'hffffffff);
    rd(12'h004, 33'h3d);
    @(posedge pclk);
    chk(exp_q.size(), 33'h0);
    $display("fault test done");
    conclude;
  end
endmodule // mel_event_latch_bench
